/* bench/cpu_bus_model.sv */
// CPU side of the memory bus: bus clock and start requests
`timescale 1ns/1ps
module cpu_bus_model
   import dram_board_pkg::*;
(
   input wire logic sys_clk,
   output logic mem_bus_clock,
   output logic mem_op_start,
   output logic mem_write_op,
   output logic [ADDR_W-1:0] mem_input_bus
);
   int div_cnt = 0;
   int slot = 0;
   initial begin
      mem_bus_clock = 1'b0;
      mem_op_start = 1'b0;
      mem_write_op = 1'b0;
      mem_input_bus = '0;
   end
   // Bus clock, high for 12 and low for 13 of every 25 sys_clk cycles
   always @(negedge sys_clk) begin
      div_cnt <= (div_cnt == int'(BUS_DIV_CLKS) - 1) ? 0 : div_cnt + 1;
      mem_bus_clock <= (div_cnt < int'(BUS_DIV_CLKS / 2));
   end
   always @(posedge mem_bus_clock) slot <= slot + 1;
   // Start with address, held over the sampling edge
   task automatic issue(input logic wr, input logic [ADDR_W-1:0] a, output int s);
      if (mem_bus_clock) @(negedge mem_bus_clock);
      @(negedge sys_clk);
      mem_op_start <= 1'b1;
      mem_write_op <= wr;
      mem_input_bus <= a;
      @(negedge mem_bus_clock);
      s = slot;
      @(negedge sys_clk);
      mem_op_start <= 1'b0;
      mem_write_op <= ~wr;
      mem_input_bus <= ~a;
      if (wr) @(negedge mem_bus_clock);
   endtask
   task automatic idle(input int n);
      repeat (n) @(negedge mem_bus_clock);
   endtask
endmodule // cpu_bus_model

/* bench/interleaved_dram_board_control_tb_top.sv */
// Self-checking bench for the interleaved dynamic RAM board control
`timescale 1ns/1ps
module interleaved_dram_board_control_tb_top
   import dram_board_pkg::*;
;
   logic sys_clk, rst_n, mem_bus_clock, mem_op_start, mem_write_op, module_busy_refusal;
   logic mem_output_valid, ram_bank_sel, refresh_active;
   logic [1:0] board_size, board_base, out_reg_sel;
   logic [ADDR_W-1:0] mem_input_bus;
   logic [DATA_W-1:0] mem_output_bus, ram_wdata, ram_rdata;
   logic [3:0] ram_ras_n, ram_cas_n, ram_we_n;
   logic [6:0] ram_addr;
   int errors = 0;
   int n_tests = 0;
   int last_slot [4];
   logic [15:0] rnd = 16'h0047;
   logic [1:0] oreg = 2'h0;
   logic [31:0] exp_ev[$], obs_ev[$], exp_dat[$], obs_dat[$];

   dram_board_ctrl u_dram_board_ctrl (.sys_clk(sys_clk), .rst_n(rst_n),
      .board_size(board_size), .board_base(board_base), .mem_bus_clock(mem_bus_clock),
      .mem_op_start(mem_op_start), .mem_write_op(mem_write_op),
      .mem_input_bus(mem_input_bus), .module_busy_refusal(module_busy_refusal),
      .mem_output_bus(mem_output_bus), .mem_output_valid(mem_output_valid),
      .ram_ras_n(ram_ras_n), .ram_cas_n(ram_cas_n), .ram_we_n(ram_we_n),
      .ram_bank_sel(ram_bank_sel), .ram_addr(ram_addr), .ram_wdata(ram_wdata),
      .ram_rdata(ram_rdata), .out_reg_sel(out_reg_sel), .refresh_active(refresh_active));
   cpu_bus_model u_cpu_bus_model (.sys_clk(sys_clk), .mem_bus_clock(mem_bus_clock),
      .mem_op_start(mem_op_start), .mem_write_op(mem_write_op),
      .mem_input_bus(mem_input_bus));

   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end
   // Event monitor
   always @(posedge sys_clk) begin
      if (module_busy_refusal === 1'b1) obs_ev.push_back(32'h00010000);
      if (ram_ras_n !== 4'hF)
         obs_ev.push_back({21'h0, ~ram_cas_n, out_reg_sel, ram_bank_sel, ~ram_ras_n});
      if (ram_we_n !== 4'hF) obs_dat.push_back({16'h0, ram_wdata});
      if (mem_output_valid === 1'b1) obs_dat.push_back({15'h0, 1'b1, mem_output_bus});
   end

   function automatic logic [15:0] lfsr(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   task automatic cmp_ev(input string n, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         errors++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic cmp_dat(input string n, input logic [31:0] e, input logic [31:0] g);
      cmp_ev({n, " data"}, e, g);
   endtask
   task automatic stop_test();
      $display("Checks %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // Reference model of one access
   task automatic op(input logic wr, input logic [ADDR_W-1:0] a);
      int s;
      int m;
      logic bk;
      m = int'(a[1:0]);
      bk = (board_size == SIZE_256K) ? a[16] : (board_size == SIZE_64K) ? a[14] : 1'b0;
      u_cpu_bus_model.issue(wr, a, s);
      if ((a >> (17 - board_size)) != 0) return;
      if (s - last_slot[m] < int'(CYCLE_CLKS / BUS_DIV_CLKS)) begin
         exp_ev.push_back(32'h00010000);
      end else begin
         last_slot[m] = s;
         exp_ev.push_back({21'h0, 4'h1 << m, oreg, bk, 4'h1 << m});
         exp_dat.push_back(wr ? {16'h0, a[15:0]} : {15'h0, 1'b1, ram_rdata});
         oreg = oreg + 2'h1;
      end
   endtask
   task automatic start_scn(input logic [1:0] sz);
      int k;
      k = 0;
      @(negedge sys_clk);
      board_size <= sz;
      rnd = lfsr(rnd);
      ram_rdata <= rnd;
      while (refresh_active !== 1'b1 && k < 8000) begin
         @(negedge sys_clk);
         k++;
      end
      while (refresh_active !== 1'b0 && k < 8000) begin
         @(negedge sys_clk);
         k++;
      end
      cmp_ev("refresh", 32'h1, {31'h0, k < 8000});
      obs_ev.delete();
      obs_dat.delete();
      exp_ev.delete();
      exp_dat.delete();
      last_slot = '{default: -100};
   endtask
   task automatic end_scn(input string n);
      repeat (60) @(negedge sys_clk);
      cmp_ev({n, " events"}, exp_ev.size(), obs_ev.size());
      cmp_dat(n, exp_dat.size(), obs_dat.size());
      foreach (exp_ev[i]) if (i < obs_ev.size()) cmp_ev(n, exp_ev[i], obs_ev[i]);
      foreach (exp_dat[i]) if (i < obs_dat.size()) cmp_dat(n, exp_dat[i], obs_dat[i]);
      $display("Test %s done", n);
   endtask

   initial begin
      repeat (90000) @(posedge sys_clk);
      errors++;
      stop_test();
   end
   initial begin
      logic [ADDR_W-1:0] b;
      board_size = SIZE_256K;
      board_base = 2'h0;
      ram_rdata = 16'h0000;
      rst_n = 1'b0;
      repeat (12) @(negedge sys_clk);
      rst_n = 1'b1;
      cmp_ev("reset strobes", 32'h0000000F, {28'h0, ram_ras_n});
      cmp_ev("reset refusal", 32'h0, {31'h0, module_busy_refusal});
      for (int sz = 0; sz < 4; sz++) begin
         start_scn(2'(sz));
         b = (sz == 0) ? 17'h10000 : (sz == 2) ? 17'h04000 : 17'h00100;
         if (sz != 0) op(1'b0, 17'h00001 << (17 - sz));
         for (int k = 0; k < 4; k++) op(1'b0, b + 17'(k));
         end_scn("sizes");
      end
      start_scn(SIZE_256K);
      op(1'b1, 17'h00005);
      op(1'b0, 17'h00009);
      u_cpu_bus_model.idle(3);
      op(1'b0, 17'h0000D);
      op(1'b1, 17'h00011);
      op(1'b0, 17'h00012);
      end_scn("busy");
      start_scn(SIZE_256K);
      repeat (8) begin
         rnd = lfsr(rnd);
         op(rnd[9], {rnd[5], rnd});
         u_cpu_bus_model.idle(rnd[9] ? 1 : 2);
      end
      end_scn("random");
      stop_test();
   end
endmodule // interleaved_dram_board_control_tb_top

/* common/dram_board_pkg.sv */
// Constants for the interleaved dynamic RAM board control
package dram_board_pkg;
   localparam int unsigned CLK_MHZ = 250;
   // Board capacity variants
   localparam logic [1:0] SIZE_256K = 2'h0;
   localparam logic [1:0] SIZE_128K = 2'h1;
   localparam logic [1:0] SIZE_64K = 2'h2;
   localparam logic [1:0] SIZE_32K = 2'h3;
   // Address field layout, bit 0 is the low word address bit
   localparam int unsigned ADDR_W = 17;
   localparam int unsigned DATA_W = 16;
   localparam int unsigned MOD_W = 2;
   localparam int unsigned NUM_MOD = 4;
   localparam int unsigned NUM_OREG = 4;
   // Words per bank in each module and bank 1 base
   localparam int unsigned BIG_RAM_BITS = 14;
   localparam int unsigned SMALL_RAM_BITS = 12;
   localparam logic [16:0] BANK1_BASE_BIG = 17'h10000;
   localparam logic [16:0] BANK1_BASE_SMALL = 17'h04000;
   localparam int unsigned BIG_ROW_W = 7;
   localparam int unsigned SMALL_ROW_W = 6;
   // Timing figures
   localparam int unsigned CYCLE_NS = 400;
   localparam int unsigned READ_ISSUE_NS = 100;
   localparam int unsigned WRITE_ISSUE_NS = 200;
   localparam int unsigned REFRESH_SMALL_NS = 25000;
   localparam int unsigned REFRESH_BIG_NS = 13000;
   localparam int unsigned BUS_CLK_MHZ = 10;
   localparam int unsigned CYCLE_CLKS = (CYCLE_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned READ_ISSUE_CLKS = (READ_ISSUE_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned WRITE_ISSUE_CLKS = (WRITE_ISSUE_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned REF_SMALL_CLKS = (REFRESH_SMALL_NS * CLK_MHZ) / 1000;
   localparam int unsigned REF_BIG_CLKS = (REFRESH_BIG_NS * CLK_MHZ) / 1000;
   localparam int unsigned BUS_DIV_CLKS = CLK_MHZ / BUS_CLK_MHZ;
   localparam logic [6:0] CYCLE_CNT = 7'(CYCLE_CLKS);
   localparam logic [12:0] REF_CNT_W = 13'h0;
endpackage

/* verilog/dram_board_ctrl.sv */
// Interleaved dynamic RAM board control logic
`timescale 1ns/1ps
module dram_board_ctrl
   import dram_board_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [1:0] board_size,
   input wire logic [1:0] board_base,
   input wire logic mem_bus_clock,
   input wire logic mem_op_start,
   input wire logic mem_write_op,
   input wire logic [ADDR_W-1:0] mem_input_bus,
   output logic module_busy_refusal,
   output logic [DATA_W-1:0] mem_output_bus,
   output logic mem_output_valid,
   output logic [NUM_MOD-1:0] ram_ras_n,
   output logic [NUM_MOD-1:0] ram_cas_n,
   output logic [NUM_MOD-1:0] ram_we_n,
   output logic ram_bank_sel,
   output logic [6:0] ram_addr,
   output logic [DATA_W-1:0] ram_wdata,
   input wire logic [DATA_W-1:0] ram_rdata,
   output logic [1:0] out_reg_sel,
   output logic refresh_active
);

   typedef enum logic [2:0] {
      M_IDLE = 3'b001,
      M_BUSY = 3'b010,
      M_REF = 3'b100
   } mod_state_t;

   // Board responds to this address for the given size and base
   function automatic logic addr_hit(input logic [1:0] sz, input logic [1:0] base,
                                     input logic [ADDR_W-1:0] a);
      logic hit;
      hit = 1'b0;
      unique case (sz)
         SIZE_256K: hit = 1'b1;
         SIZE_128K: hit = (a[16] == base[0]);
         SIZE_64K: hit = (a[16:15] == base);
         SIZE_32K: hit = (a[16:14] == {base, 1'b0});
      endcase
      return hit;
   endfunction

   logic [ADDR_W-1:0] din_reg;
   logic start_reg, write_reg, bclk_reg;
   logic take;
   logic [MOD_W-1:0] mod_idx;
   logic hit;
   logic bank;
   mod_state_t state_reg [NUM_MOD];
   logic [6:0] cnt_reg [NUM_MOD];
   logic [NUM_MOD-1:0] idle_vec;
   logic [1:0] oreg_ptr_reg;
   logic [DATA_W-1:0] oreg [NUM_OREG];
   logic [12:0] ref_cnt_reg;
   logic [13:0] ref_addr_reg;
   logic ref_due_reg;
   logic [6:0] row_field, col_field;
   logic [NUM_OREG-1:0] pend_rd_reg;
   logic [6:0] rd_cnt_reg [NUM_OREG];

   // Bus sampled on rising edge of the memory bus clock
   assign take = mem_bus_clock & ~bclk_reg;

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         bclk_reg <= 1'b0;
         start_reg <= 1'b0;
         write_reg <= 1'b0;
         din_reg <= '0;
      end else begin
         bclk_reg <= mem_bus_clock;
         start_reg <= take & mem_op_start;
         if (take) begin
            write_reg <= mem_write_op;
            din_reg <= mem_input_bus;
         end
      end
   end

   assign mod_idx = din_reg[MOD_W-1:0];
   assign hit = addr_hit(board_size, board_base, din_reg);
   // Bank bit only on two-bank variants
   always_comb begin
      bank = 1'b0;
      row_field = '0;
      col_field = '0;
      unique case (board_size)
         SIZE_256K: bank = din_reg[16];
         SIZE_64K: bank = din_reg[14];
         default: bank = 1'b0;
      endcase
      if (board_size == SIZE_256K || board_size == SIZE_128K) begin
         row_field = din_reg[15:9];
         col_field = din_reg[8:2];
      end else begin
         row_field = {1'b0, din_reg[13:8]};
         col_field = {1'b0, din_reg[7:2]};
      end
   end

   generate
      for (genvar m = 0; m < NUM_MOD; m++) begin : g_mod
         assign idle_vec[m] = (state_reg[m] == M_IDLE);
         // Independent per-module cycle timer
         always_ff @(posedge sys_clk) begin
            if (!rst_n) begin
               state_reg[m] <= M_IDLE;
               cnt_reg[m] <= '0;
            end else begin
               unique case (state_reg[m])
                  M_IDLE: begin
                     if (start_reg && hit && mod_idx == m) begin
                        state_reg[m] <= M_BUSY;
                        cnt_reg[m] <= CYCLE_CNT - 7'h01;
                     end else if (ref_due_reg && &idle_vec) begin
                        state_reg[m] <= M_REF;
                        cnt_reg[m] <= CYCLE_CNT - 7'h01;
                     end
                  end
                  M_BUSY, M_REF: begin
                     if (cnt_reg[m] == 7'h00) state_reg[m] <= M_IDLE;
                     else cnt_reg[m] <= cnt_reg[m] - 7'h01;
                  end
               endcase
            end
         end
      end
   endgenerate

   // Refresh period timer by board size
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         ref_cnt_reg <= '0;
         ref_due_reg <= 1'b0;
         ref_addr_reg <= '0;
      end else begin
         if (ref_due_reg && &idle_vec && !(start_reg && hit)) begin
            ref_due_reg <= 1'b0;
            ref_addr_reg <= ref_addr_reg + 14'h0001;
         end
         if ((board_size[1] && ref_cnt_reg == 13'(REF_SMALL_CLKS - 1)) ||
             (!board_size[1] && ref_cnt_reg == 13'(REF_BIG_CLKS - 1))) begin
            ref_cnt_reg <= '0;
            ref_due_reg <= 1'b1;
         end else begin
            ref_cnt_reg <= ref_cnt_reg + 13'h0001;
         end
      end
   end

   // Busy refusal, RAM strobes and data path
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         module_busy_refusal <= 1'b0;
         ram_ras_n <= '1;
         ram_cas_n <= '1;
         ram_we_n <= '1;
         ram_bank_sel <= 1'b0;
         ram_addr <= '0;
         ram_wdata <= '0;
         refresh_active <= 1'b0;
      end else begin
         module_busy_refusal <= start_reg && hit && !idle_vec[mod_idx];
         refresh_active <= (state_reg[0] == M_REF);
         ram_ras_n <= '1;
         ram_cas_n <= '1;
         ram_we_n <= '1;
         if (start_reg && hit && idle_vec[mod_idx]) begin
            ram_ras_n[mod_idx] <= 1'b0;
            ram_cas_n[mod_idx] <= 1'b0;
            ram_we_n[mod_idx] <= ~write_reg;
            ram_bank_sel <= bank;
            ram_addr <= row_field ^ col_field;
            ram_wdata <= din_reg[DATA_W-1:0];
         end else if (ref_due_reg && &idle_vec) begin
            ram_ras_n <= '0;
            ram_addr <= ref_addr_reg[6:0];
         end
      end
   end

   // Read capture into rotating output registers, one pending read per register
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         pend_rd_reg <= '0;
         oreg_ptr_reg <= '0;
         out_reg_sel <= '0;
         mem_output_bus <= '0;
         mem_output_valid <= 1'b0;
         for (int i = 0; i < NUM_OREG; i++) begin
            rd_cnt_reg[i] <= '0;
            oreg[i] <= '0;
         end
      end else begin
         mem_output_valid <= 1'b0;
         // Reads overlap, so each register times its own read
         for (int i = 0; i < NUM_OREG; i++) begin
            if (pend_rd_reg[i]) begin
               if (rd_cnt_reg[i] == 7'h00) begin
                  pend_rd_reg[i] <= 1'b0;
                  oreg[i] <= ram_rdata;
                  mem_output_bus <= ram_rdata;
                  mem_output_valid <= 1'b1;
               end else begin
                  rd_cnt_reg[i] <= rd_cnt_reg[i] - 7'h01;
               end
            end
         end
         if (start_reg && hit && idle_vec[mod_idx]) begin
            oreg_ptr_reg <= oreg_ptr_reg + 2'h1;
            out_reg_sel <= oreg_ptr_reg;
            pend_rd_reg[oreg_ptr_reg] <= ~write_reg;
            rd_cnt_reg[oreg_ptr_reg] <= 7'(READ_ISSUE_CLKS);
         end
      end
   end

   property p_refuse_busy;
      @(posedge sys_clk) disable iff (!rst_n)
      (start_reg && hit && !idle_vec[mod_idx]) |=> module_busy_refusal;
   endproperty
   a_refuse_busy: assert property (p_refuse_busy) else $error("busy not refused");

   property p_hold_cycle;
      @(posedge sys_clk) disable iff (!rst_n)
      $rose(state_reg[0] == M_BUSY) |-> (state_reg[0] == M_BUSY)[*8];
   endproperty
   a_hold_cycle: assert property (p_hold_cycle) else $error("module freed early");

   property p_free_after;
      @(posedge sys_clk) disable iff (!rst_n)
      $rose(state_reg[1] == M_BUSY) |-> ##[1:100] (state_reg[1] == M_IDLE);
   endproperty
   a_free_after: assert property (p_free_after) else $error("module stuck busy");

   property p_rotate;
      @(posedge sys_clk) disable iff (!rst_n)
      (start_reg && hit && idle_vec[mod_idx]) |=> out_reg_sel == $past(oreg_ptr_reg);
   endproperty
   a_rotate: assert property (p_rotate) else $error("output register out of order");

   property p_no_write_refused;
      @(posedge sys_clk) disable iff (!rst_n)
      module_busy_refusal |-> &ram_we_n;
   endproperty
   a_no_write_refused: assert property (p_no_write_refused) else $error("refused write");

   property p_ref_idle;
      @(posedge sys_clk) disable iff (!rst_n)
      $rose(state_reg[2] == M_REF) |-> $past(&idle_vec);
   endproperty
   a_ref_idle: assert property (p_ref_idle) else $error("refresh while busy");

   property p_module_pick;
      @(posedge sys_clk) disable iff (!rst_n)
      (start_reg && hit && idle_vec[mod_idx]) |=> !ram_ras_n[$past(mod_idx)];
   endproperty
   a_module_pick: assert property (p_module_pick) else $error("wrong module");

   property p_out_range;
      @(posedge sys_clk) disable iff (!rst_n)
      (start_reg && !hit) |=> (&ram_cas_n && !module_busy_refusal);
   endproperty
   a_out_range: assert property (p_out_range) else $error("responded out of range");

endmodule // dram_board_ctrl
